// ===== core/dmam_defines.svh
// Offsets, field positions, reset values and sizes of the data memory map
`ifndef DMAM_DEFINES_SVH
`define DMAM_DEFINES_SVH
`define DMAM_PAGE_CTRL_ADDR 8'hE7
`define DMAM_SP_ADDR 8'h81
`define DMAM_PSW_ADDR 8'hD0
`define DMAM_PAGE_MSB 3
`define DMAM_PAGE_LSB 0
`define DMAM_PAGE_RESET 4'h0
`define DMAM_SP_RESET 8'h07
`define DMAM_PSW_RESET 8'h00
`define DMAM_BANK_LOW_BIT 3
`define DMAM_BANK_HIGH_BIT 4
`define DMAM_LOWER_TOP 8'h7F
`define DMAM_BIT_BASE 8'h20
`define DMAM_EXPANSION_RAM_SIZE 32'd4096
`endif

// ===== core/dmam_pkg.sv
// Types shared by the data memory map block
`default_nettype none
package dmam_pkg;
  typedef enum logic [2:0] {
    DMAM_DIRECT = 3'h0,
    DMAM_INDIRECT = 3'h1,
    DMAM_BIT = 3'h2,
    DMAM_PUSH = 3'h3,
    DMAM_POP = 3'h4,
    DMAM_XMOV8 = 3'h5,
    DMAM_XMOV16 = 3'h6
  } dmam_mode_e;
endpackage
`default_nettype wire

// ===== core/dmam_map.sv
// Data memory map: internal RAM, SFR split, banks, bits, stack, expansion_ram
// Contract
// RL1 - 256 bytes internal RAM, separate space
// RL2 - Lower 128 bytes direct or indirect
// RL3 - Above 0x7F: direct SFR, indirect RAM
// RL4 - Four register banks chosen by PROGRAM_STATUS_WORD
// RL5 - Indirect pointers are bank registers 0,1
// RL6 - Bytes 0x20-0x2F hold 128 bits
// RL7 - Bit or byte access by operand
// RL8 - Push increments SP, then writes
// RL9 - Reset loads SP with 0x07
// RL10 - Stack anywhere in 256 bytes
// RL11 - 64 KB code space, no data fetch
// RL12 - Code reads flash; xmov writes RAM/flash
// RL13 - Extra RAM only via xmov
// RL14 - Page field gives 8-bit xmov high byte
// RL15 - Page control bits 7:4 read zero
// RL16 - Pop reads, then decrements SP
`include "dmam_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module dmam_map #(
  parameter int EXPANSION_RAM_BYTES = `DMAM_EXPANSION_RAM_SIZE
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic req,
  input wire dmam_pkg::dmam_mode_e mode,
  input wire logic wr,
  input wire logic [7:0] addr,
  input wire logic [15:0] xaddr,
  input wire logic ptr_sel,
  input wire logic [7:0] wdata,
  input wire logic flash_write_en,
  input wire logic [15:0] code_addr,
  input wire logic [7:0] sfr_rdata,
  output logic [7:0] rdata,
  output logic sfr_req,
  output logic sfr_wr,
  output logic [7:0] sfr_addr,
  output logic [7:0] sfr_wdata,
  output logic flash_req,
  output logic [15:0] flash_addr,
  output logic [7:0] flash_wdata,
  output logic [15:0] code_fetch_addr,
  output logic [7:0] stack_pointer,
  output logic [1:0] active_bank
);
  // Expansion RAM must fit the 16-bit move-external address space
  initial begin
    if (EXPANSION_RAM_BYTES < 1)
      $error("EXPANSION_RAM_BYTES must be at least one byte");
    if (EXPANSION_RAM_BYTES > 65536)
      $error("EXPANSION_RAM_BYTES exceeds the 16-bit address space");
  end
  localparam int XW = (EXPANSION_RAM_BYTES > 1) ? $clog2(EXPANSION_RAM_BYTES) : 1;

  // RL1 internal RAM, lower and upper halves in one array
  logic [7:0] iram_q [256];
  logic [7:0] expansion_ram_q [EXPANSION_RAM_BYTES];
  logic [7:0] sp_q, psw_q, rdata_q;
  logic [3:0] expansion_ram_page_field_q;

  function automatic logic [7:0] bit_byte(input logic [7:0] b);
    bit_byte = `DMAM_BIT_BASE + {4'h0, b[6:3]};
  endfunction

  // RL7 one bit of a byte replaced, the rest kept
  function automatic logic [7:0] bit_merge(input logic [7:0] old_byte,
                                           input logic [2:0] pos,
                                           input logic val);
    logic [7:0] mask;
    mask = 8'h01 << pos;
    bit_merge = val ? (old_byte | mask) : (old_byte & ~mask);
  endfunction

  // Registers held here; direct accesses to them are kept off the SFR port, bit accesses (PSW at 0xD0) are not
  function automatic logic own_addr(input logic [7:0] a);
    own_addr = (a == `DMAM_PAGE_CTRL_ADDR) || (a == `DMAM_SP_ADDR) ||
               (a == `DMAM_PSW_ADDR);
  endfunction

  wire logic is_direct = (mode == dmam_pkg::DMAM_DIRECT);
  wire logic is_indirect = (mode == dmam_pkg::DMAM_INDIRECT);
  wire logic is_bit = (mode == dmam_pkg::DMAM_BIT);
  wire logic is_push = (mode == dmam_pkg::DMAM_PUSH);
  wire logic is_pop = (mode == dmam_pkg::DMAM_POP);
  wire logic is_x8 = (mode == dmam_pkg::DMAM_XMOV8);
  wire logic is_x16 = (mode == dmam_pkg::DMAM_XMOV16);
  // RL4 bank select bits
  wire logic [1:0] bank = {psw_q[`DMAM_BANK_HIGH_BIT],
                           psw_q[`DMAM_BANK_LOW_BIT]};
  // RL5 pointer register address in active bank
  wire logic [7:0] ptr_addr = {3'h0, bank, 2'h0, ptr_sel};
  wire logic [7:0] ptr_val = iram_q[ptr_addr];
  // RL8 push target is SP+1
  wire logic [7:0] sp_inc = sp_q + 8'h01;
  // RL3 direct above 0x7F goes to SFR
  wire logic dir_sfr = is_direct && (addr > `DMAM_LOWER_TOP);
  wire logic own_sfr = dir_sfr && own_addr(addr);
  // RL2 RL3 RL10 internal RAM address by mode
  wire logic [7:0] iaddr = is_indirect ? ptr_val :
                           is_push ? sp_inc :
                           is_pop ? sp_q :
                           is_bit ? bit_byte(addr) : addr;
  wire logic iram_sel = is_indirect || is_push || is_pop ||
                        (is_direct && !dir_sfr) ||
                        (is_bit && !addr[7]);
  // RL14 RL15 8-bit xmov high byte from page field
  wire logic [15:0] xa = is_x8 ? {4'h0, expansion_ram_page_field_q, ptr_val} : xaddr;
  wire logic x_hit = (is_x8 || is_x16) && ({16'h0, xa} < EXPANSION_RAM_BYTES);
  // RL12 flash path when reconfigured
  wire logic to_flash = is_x16 && wr && flash_write_en;
  wire logic [7:0] iram_byte = iram_q[iaddr];
  // RL7 bit access modifies one bit only
  wire logic [7:0] bit_new = bit_merge(iram_byte, addr[2:0], wdata[0]);
  // RL7 SFR bit write is a read-modify-write of the whole byte, so the
  // SFR side must answer reads combinationally while sfr_req is high
  wire logic sfr_bit = is_bit && addr[7];
  wire logic [7:0] sfr_bit_new = bit_merge(sfr_rdata, addr[2:0], wdata[0]);
  wire logic [7:0] own_rd =
    (addr == `DMAM_PAGE_CTRL_ADDR) ? {4'h0, expansion_ram_page_field_q} :
    (addr == `DMAM_SP_ADDR) ? sp_q : psw_q;

  assign sfr_req = req && (dir_sfr || (is_bit && addr[7])) && !own_sfr;
  assign sfr_wr = wr;
  assign sfr_addr = is_bit ? {addr[7:3], 3'h0} : addr;
  assign sfr_wdata = sfr_bit ? sfr_bit_new : wdata;
  assign flash_req = req && to_flash;
  assign flash_addr = xaddr;
  assign flash_wdata = wdata;
  // RL11 code fetch only from 64 KB program space
  assign code_fetch_addr = code_addr;
  assign stack_pointer = sp_q;
  assign active_bank = bank;
  assign rdata = rdata_q;

  // RL1 RL2 internal RAM write, byte or single bit
  wire logic iram_we = req && wr && iram_sel;
  wire logic [7:0] iram_wdata = is_bit ? bit_new : wdata;
  // RL13 extra RAM only reached by xmov; a miss is dropped
  wire logic expansion_ram_we = req && wr && x_hit && !to_flash;

  // RAM has no reset: contents survive a reset, as software expects
  always_ff @(posedge ref_clk) begin
    if (iram_we)
      iram_q[iaddr] <= iram_wdata;
  end

  always_ff @(posedge ref_clk) begin
    if (expansion_ram_we)
      expansion_ram_q[xa[XW-1:0]] <= wdata;
  end

  // Writes to the registers kept inside this block
  wire logic sp_wr = own_sfr && wr && (addr == `DMAM_SP_ADDR);
  wire logic psw_wr = own_sfr && wr && (addr == `DMAM_PSW_ADDR);
  wire logic page_wr = own_sfr && wr && (addr == `DMAM_PAGE_CTRL_ADDR);
  // RL16 pop decrements after the read
  wire logic [7:0] sp_dec = sp_q - 8'h01;
  // RL8 push or pop wins over a direct write in the same cycle
  wire logic [7:0] sp_d = !req ? sp_q :
                          is_push ? sp_inc :
                          is_pop ? sp_dec :
                          sp_wr ? wdata : sp_q;
  wire logic [7:0] psw_d = (req && psw_wr) ? wdata : psw_q;
  // RL14 RL15 only the page field is stored, so bits 7:4 read zero
  wire logic [3:0] expansion_ram_page_field_d = (req && page_wr) ?
    wdata[`DMAM_PAGE_MSB:`DMAM_PAGE_LSB] : expansion_ram_page_field_q;
  // RL7 bit reads return the addressed bit in bit 0
  wire logic [7:0] sfr_rd = sfr_bit ? {7'h0, sfr_rdata[addr[2:0]]} :
                            sfr_rdata;
  wire logic [7:0] iram_rd = is_bit ? {7'h0, iram_byte[addr[2:0]]} :
                             iram_byte;
  // An xmov miss returns the SFR read bus rather than stale data
  wire logic [7:0] rd_sel = iram_sel ? iram_rd :
                            own_sfr ? own_rd :
                            x_hit ? expansion_ram_q[xa[XW-1:0]] : sfr_rd;
  // Read data stands until the next read request
  wire logic [7:0] rdata_d = (req && !wr) ? rd_sel : rdata_q;

  // RL9 stack pointer reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst)
      sp_q <= `DMAM_SP_RESET;
    else
      sp_q <= sp_d;
  end

  // RL4 bank bits cleared by reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst)
      psw_q <= `DMAM_PSW_RESET;
    else
      psw_q <= psw_d;
  end

  // RL14 page field reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst)
      expansion_ram_page_field_q <= `DMAM_PAGE_RESET;
    else
      expansion_ram_page_field_q <= expansion_ram_page_field_d;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst)
      rdata_q <= 8'h00;
    else
      rdata_q <= rdata_d;
  end
endmodule // dmam_map
`default_nettype wire

// ===== testbench/dmam_map_assertions.sv
// Port checker for the data memory map
`timescale 1ns/100ps
`default_nettype none
module dmam_map_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic req,
  input wire dmam_pkg::dmam_mode_e mode,
  input wire logic wr,
  input wire logic [7:0] addr,
  input wire logic flash_write_en,
  input wire logic [7:0] sfr_rdata,
  input wire logic [7:0] rdata,
  input wire logic sfr_req,
  input wire logic [7:0] sfr_addr,
  input wire logic flash_req,
  input wire logic [7:0] stack_pointer
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Own registers stay local, so they are kept out of the SFR cases
  wire logic dsfr = req && mode == dmam_pkg::DMAM_DIRECT && addr > 8'h7F &&
    !(addr inside {8'hE7, 8'h81, 8'hD0});
  sequence s_sfr_rd;
    dsfr && !wr;
  endsequence
  chk_sp_reset: assert property ($fell(rst) |-> stack_pointer == 8'h07)
    else $error("sp not 07");
  chk_push_inc: assert property (req && mode == dmam_pkg::DMAM_PUSH |=>
    stack_pointer == $past(stack_pointer) + 8'h01) else $error("push sp");
  chk_pop_dec: assert property (req && mode == dmam_pkg::DMAM_POP |=>
    stack_pointer == $past(stack_pointer) - 8'h01) else $error("pop sp");
  chk_sfr_route: assert property (dsfr |-> sfr_req && sfr_addr == addr)
    else $error("sfr route");
  chk_sfr_read: assert property (s_sfr_rd |=> rdata == $past(sfr_rdata))
    else $error("sfr read");
  chk_ind_local: assert property (req && mode == dmam_pkg::DMAM_INDIRECT
    |-> !sfr_req) else $error("indirect hit sfr");
  chk_flash_route: assert property (req && wr && flash_write_en &&
    mode == dmam_pkg::DMAM_XMOV16 |-> flash_req) else $error("no flash");
  chk_flash_off: assert property (!flash_write_en |-> !flash_req)
    else $error("stray flash");
endmodule // dmam_map_chk
bind dmam_map dmam_map_chk u_chk (.*);
`default_nettype wire

// ===== testbench/dmam_sfr_model.sv
// SFR side model answering forwarded direct accesses
`timescale 1ns/100ps
`default_nettype none
module dmam_sfr_model (
  input wire logic ref_clk,
  input wire logic sfr_req,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata
);
  logic [7:0] mem [256];
  logic [7:0] junk = 8'h5A;
  // Unselected: a changing pattern so a stale capture cannot match
  assign sfr_rdata = sfr_req ? mem[sfr_addr] : junk;
  always @(posedge ref_clk) begin
    junk <= junk + 8'h3B;
    if (sfr_req && sfr_wr) mem[sfr_addr] <= sfr_wdata;
  end
endmodule // dmam_sfr_model
`default_nettype wire

// ===== testbench/tb_top.sv
// Bench: core-side stimulus with queued read checks
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module tb_top;
  logic ref_clk = 1'h0, rst = 1'h1, req = 1'h0, wr = 1'h0, pend;
  logic flash_write_en = 1'h0, sfr_req, sfr_wr;
  logic [7:0] addr = 8'h00, wdata = 8'h00, sfr_rdata, rdata, sfr_addr, v, e;
  logic [7:0] sfr_wdata, stack_pointer, exq[$];
  logic [15:0] xaddr = 16'h0000, code_addr = 16'h0000;
  logic [1:0] active_bank;
  logic ptr_sel = 1'h0, flash_req;
  logic [15:0] flash_addr, code_fetch_addr;
  logic [7:0] flash_wdata;
  dmam_pkg::dmam_mode_e mode = dmam_pkg::DMAM_DIRECT;
  int n_fail = 0, checks_done = 0;
  dmam_map #(.EXPANSION_RAM_BYTES(1024)) u_dut (.*);
  dmam_sfr_model u_sfr (.*);
  initial forever #4 ref_clk = ~ref_clk;
  initial begin
    repeat (3000) @(posedge ref_clk);
    n_fail++;
    give_verdict();
  end
  always @(posedge ref_clk) begin
    if (pend) begin
      e = exq.pop_front();
      `CHK("rdata", e, rdata)
    end
    pend <= req && !wr;
  end
  task automatic a(logic [2:0] m, logic w, logic [7:0] ad, d);
    {req, wr, addr, wdata} <= {1'h1, w, ad, d};
    mode <= dmam_pkg::dmam_mode_e'(m);
    if (!w) exq.push_back(d);
    @(posedge ref_clk);
    #1;
  endtask
  task automatic give_verdict();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h67B1));
    v = $urandom;
    code_addr = 16'($urandom);
    repeat (10) @(posedge ref_clk);
    #1 rst = 1'h0;
    `CHK("sp", 8'h07, stack_pointer)
    `CHK("code", code_addr, code_fetch_addr)
    a(3'h0, 1'h1, 8'h00, 8'h90); a(3'h0, 1'h1, 8'h90, ~v); a(3'h1, 1'h1, 8'h00, v);
    a(3'h0, 1'h0, 8'h90, ~v); a(3'h1, 1'h0, 8'h00, v);
    a(3'h0, 1'h1, 8'h22, 8'h00); a(3'h2, 1'h1, 8'h13, 8'h01);
    a(3'h0, 1'h0, 8'h22, 8'h08);
    // SFR bit set keeps the other bits; bit reads give one bit
    a(3'h2, 1'h1, 8'h93, 8'h01); a(3'h0, 1'h0, 8'h90, ~v | 8'h08);
    a(3'h2, 1'h0, 8'h93, 8'h01); a(3'h2, 1'h0, 8'h13, 8'h01);
    a(3'h3, 1'h1, 8'h00, v);
    `CHK("sp", 8'h08, stack_pointer)
    a(3'h0, 1'h0, 8'h08, v); a(3'h4, 1'h0, 8'h00, v);
    `CHK("sp", 8'h07, stack_pointer)
    a(3'h0, 1'h1, 8'h08, 8'h40); a(3'h0, 1'h1, 8'hD0, 8'h08);
    `CHK("bank", 2'h1, active_bank)
    a(3'h1, 1'h1, 8'h00, ~v); a(3'h0, 1'h0, 8'h40, ~v);
    a(3'h0, 1'h1, 8'h09, 8'hA0);
    ptr_sel <= 1'h1;
    a(3'h1, 1'h1, 8'h00, v); a(3'h1, 1'h0, 8'h00, v);
    ptr_sel <= 1'h0;
    // upper nibble written as zero, reads back zero
    a(3'h0, 1'h1, 8'hE7, 8'h03); a(3'h0, 1'h0, 8'hE7, 8'h03);
    a(3'h5, 1'h1, 8'h00, v);
    xaddr <= 16'h0340;
    a(3'h6, 1'h0, 8'h00, v);
    `CHK("no_flash", 1'h0, flash_req)
    flash_write_en <= 1'h1;
    a(3'h6, 1'h1, 8'h00, v);
    `CHK("flash_req", 1'h1, flash_req)
    `CHK("flash_addr", 16'h0340, flash_addr)
    `CHK("flash_data", v, flash_wdata)
    req <= 1'h0;
    flash_write_en <= 1'h0;
    repeat (3) @(posedge ref_clk);
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
